// >>> i2c_cond_device.sv
/*
  Device end of the two-wire port: synchronises the bus, detects Start,
  Stop and Restart, runs a 10-bit addressed slave with clock holding,
  and can itself open and close the bus as master with collision check.
  Assumes the shared bus interface and a single clock with sync reset.
*/
`timescale 1ns/100ps
`default_nettype none

module i2c_cond_device (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus
  i2c_link_if.dev lnk,
  // Configuration
  input wire logic [9:0] own_addr_i,
  input wire logic start_detect_irq_enable_i,
  input wire logic stop_detect_irq_enable_i,
  input wire logic native_cond_irq_i,
  // Master requests
  input wire logic gen_start_i,
  input wire logic gen_stop_i,
  // Slave transmit data
  input wire logic tx_load_i,
  input wire logic [7:0] tx_data_i,
  // Bus conditions
  output logic start_det_o,
  output logic stop_det_o,
  output logic restart_det_o,
  output logic bus_active_o,
  output logic bus_collision_o,
  output logic master_own_o,
  // Slave status
  output logic prior_match_o,
  output logic addr_match_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic tx_req_o,
  output logic irq_o
);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_ACK = 3'h2,
    S_HOLD = 3'h3,
    S_TX = 3'h4,
    S_TXACK = 3'h5
  } slv_state_t;

  typedef enum logic [1:0] {
    P_HI = 2'h0,
    P_LO = 2'h1,
    P_DATA = 2'h2
  } phase_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_CHECK = 3'h1,
    M_SDA = 3'h2,
    M_OWN = 3'h3,
    M_STOP = 3'h4
  } mst_state_t;

  localparam logic [i2c_cond_pkg::TMR_W-1:0] HOLD =
    i2c_cond_pkg::TMR_W'(i2c_cond_pkg::START_HOLD_CYC);

  logic sda_m, sda_s, sda_p, scl_m, scl_s, scl_p;
  logic scl_rise, scl_fall, start_c, stop_c, hi_match;
  logic bus_active, next_bus_active, scl_low_seen, next_scl_low_seen;
  logic prior, next_prior, go_tx, next_go_tx, txack_ok, next_txack_ok;
  slv_state_t st, next_st;
  phase_t ph, next_ph;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, tx, next_tx, rx_data, next_rx_data;
  logic sda_drv, next_sda_drv, scl_drv, next_scl_drv;
  logic start_det, restart_det, stop_det, next_restart;
  logic rx_valid, next_rx_valid, addr_match, next_addr_match;
  logic irq, next_irq, tx_req;
  mst_state_t mst, next_mst;
  logic [i2c_cond_pkg::TMR_W-1:0] mtmr, next_mtmr;
  logic msda, next_msda, mscl, next_mscl, coll, next_coll;
  logic mown;

  // ****************************************************************
  // Condition detection
  // ****************************************************************
  // Edges are judged on synchronised samples only
  always_comb begin
    scl_rise = scl_s & ~scl_p;
    scl_fall = ~scl_s & scl_p;
    start_c = scl_s & scl_p & sda_p & ~sda_s;
    // SDA dip with SCL high throughout gives only a Start
    stop_c = scl_s & scl_p & ~sda_p & sda_s & scl_low_seen;
    hi_match = (sh[7:3] == i2c_cond_pkg::ADDR10_PREFIX) & (sh[2:1] == own_addr_i[9:8]);
  end

  // ****************************************************************
  // Slave
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_ph = ph;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_rx_data = rx_data;
    next_sda_drv = sda_drv;
    next_scl_drv = scl_drv;
    next_prior = prior;
    next_go_tx = go_tx;
    next_txack_ok = txack_ok;
    next_bus_active = bus_active;
    next_restart = 1'b0;
    next_rx_valid = 1'b0;
    next_addr_match = 1'b0;
    next_scl_low_seen = start_c ? 1'b0 : (scl_low_seen | ~scl_s);
    if (start_c) begin
      // Restart wipes the slave exactly like a Start
      next_restart = bus_active & scl_low_seen;
      next_bus_active = 1'b1;
      next_st = S_RX;
      next_ph = P_HI;
      next_cnt = i2c_cond_pkg::CNT_ZERO;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
      next_go_tx = 1'b0;
    end else if (stop_c) begin
      next_bus_active = 1'b0;
      next_prior = 1'b0;
      next_st = S_IDLE;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
    end else begin
      case (st)
        S_IDLE: next_st = S_IDLE;
        S_RX: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda_s};
            next_cnt = cnt + i2c_cond_pkg::CNT_ONE;
          end else if (scl_fall && cnt == i2c_cond_pkg::BYTE_BITS) begin
            next_st = S_ACK;
            next_sda_drv = 1'b1;
            next_go_tx = 1'b0;
            case (ph)
              P_HI: begin
                if (!hi_match) begin
                  next_prior = 1'b0;
                  next_st = S_IDLE;
                  next_sda_drv = 1'b0;
                end else if (!sh[0]) begin
                  next_prior = 1'b0;
                  next_ph = P_LO;
                end else if (prior) begin
                  next_go_tx = 1'b1;
                end else begin
                  next_st = S_IDLE;
                  next_sda_drv = 1'b0;
                end
              end
              P_LO: begin
                if (sh == own_addr_i[7:0]) begin
                  next_prior = 1'b1;
                  next_addr_match = 1'b1;
                  next_ph = P_DATA;
                end else begin
                  next_st = S_IDLE;
                  next_sda_drv = 1'b0;
                end
              end
              default: begin
                next_rx_valid = 1'b1;
                next_rx_data = sh;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            next_sda_drv = 1'b0;
            next_cnt = i2c_cond_pkg::CNT_ZERO;
            next_st = go_tx ? S_HOLD : S_RX;
            next_scl_drv = go_tx;
          end
        end
        S_HOLD: begin
          if (tx_load_i) begin
            next_tx = tx_data_i;
            next_sda_drv = ~tx_data_i[7];
            next_scl_drv = 1'b0;
            next_cnt = i2c_cond_pkg::CNT_ZERO;
            next_st = S_TX;
          end
        end
        S_TX: begin
          if (scl_rise) begin
            next_cnt = cnt + i2c_cond_pkg::CNT_ONE;
          end else if (scl_fall) begin
            if (cnt == i2c_cond_pkg::BYTE_BITS) begin
              next_sda_drv = 1'b0;
              next_st = S_TXACK;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_sda_drv = ~tx[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            next_txack_ok = ~sda_s;
          end else if (scl_fall) begin
            // Acknowledged byte: hold the clock again for the next one
            next_st = txack_ok ? S_HOLD : S_IDLE;
            next_scl_drv = txack_ok;
          end
        end
        default: next_st = S_IDLE;
      endcase
    end
    // Enables only widen the set of interrupt sources
    next_irq = (start_c & (native_cond_irq_i | start_detect_irq_enable_i)) |
               (stop_c & (native_cond_irq_i | stop_detect_irq_enable_i)) |
               next_rx_valid | next_addr_match | (next_st == S_HOLD && st != S_HOLD);
  end

  // ****************************************************************
  // Master open and close
  // ****************************************************************
  always_comb begin
    next_mst = mst;
    next_mtmr = mtmr;
    next_msda = msda;
    next_mscl = mscl;
    next_coll = 1'b0;
    case (mst)
      M_IDLE: if (gen_start_i && !bus_active) next_mst = M_CHECK;
      M_CHECK: begin
        // Line sampled low before we pulled it: someone else got there
        if (!sda_s || start_c) begin
          next_coll = 1'b1;
          next_mst = M_IDLE;
        end else begin
          next_msda = 1'b1;
          next_mtmr = HOLD;
          next_mst = M_SDA;
        end
      end
      M_SDA: begin
        if (mtmr == i2c_cond_pkg::TMR_ZERO) begin
          next_mscl = 1'b1;
          next_mst = M_OWN;
        end else begin
          next_mtmr = mtmr - 9'h001;
        end
      end
      M_OWN: begin
        if (gen_stop_i) begin
          next_mscl = 1'b0;
          next_mtmr = HOLD;
          next_mst = M_STOP;
        end
      end
      M_STOP: begin
        if (scl_s && mtmr == i2c_cond_pkg::TMR_ZERO) begin
          next_msda = 1'b0;
          next_mst = M_IDLE;
        end else if (scl_s) begin
          next_mtmr = mtmr - 9'h001;
        end
      end
      default: next_mst = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {sda_m, sda_s, sda_p, scl_m, scl_s, scl_p} <= 6'h3f;
      bus_active <= 1'b0;
      scl_low_seen <= 1'b0;
      prior <= 1'b0;
      go_tx <= 1'b0;
      txack_ok <= 1'b0;
      st <= S_IDLE;
      ph <= P_HI;
      cnt <= i2c_cond_pkg::CNT_ZERO;
      sh <= 8'h00;
      tx <= 8'h00;
      rx_data <= 8'h00;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
      start_det <= 1'b0;
      restart_det <= 1'b0;
      stop_det <= 1'b0;
      rx_valid <= 1'b0;
      addr_match <= 1'b0;
      irq <= 1'b0;
      tx_req <= 1'b0;
      mst <= M_IDLE;
      mtmr <= i2c_cond_pkg::TMR_ZERO;
      msda <= 1'b0;
      mscl <= 1'b0;
      coll <= 1'b0;
      mown <= 1'b0;
    end else begin
      sda_m <= lnk.sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
      scl_m <= lnk.scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      bus_active <= next_bus_active;
      scl_low_seen <= next_scl_low_seen;
      prior <= next_prior;
      go_tx <= next_go_tx;
      txack_ok <= next_txack_ok;
      st <= next_st;
      ph <= next_ph;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      rx_data <= next_rx_data;
      sda_drv <= next_sda_drv;
      scl_drv <= next_scl_drv;
      start_det <= start_c;
      restart_det <= next_restart;
      stop_det <= stop_c;
      rx_valid <= next_rx_valid;
      addr_match <= next_addr_match;
      irq <= next_irq;
      tx_req <= (next_st == S_HOLD);
      mst <= next_mst;
      mtmr <= next_mtmr;
      msda <= next_msda;
      mscl <= next_mscl;
      coll <= next_coll;
      mown <= (next_mst == M_OWN);
    end
  end

  assign lnk.dev_sda_o = 1'b0;
  assign lnk.dev_scl_o = 1'b0;
  assign lnk.dev_sda_oe_n = ~(sda_drv | msda);
  assign lnk.dev_scl_oe_n = ~(scl_drv | mscl);
  assign start_det_o = start_det;
  assign stop_det_o = stop_det;
  assign restart_det_o = restart_det;
  assign bus_active_o = bus_active;
  assign bus_collision_o = coll;
  assign master_own_o = mown;
  assign prior_match_o = prior;
  assign addr_match_o = addr_match;
  assign rx_valid_o = rx_valid;
  assign rx_data_o = rx_data;
  assign tx_req_o = tx_req;
  assign irq_o = irq;

endmodule

`default_nettype wire

// >>> i2c_cond_host.sv
/*
  Far-end bus master: makes SCL by dividing its own clock, and issues
  Start, Restart, byte write, byte read and Stop on command.
  Assumes the shared bus interface and a single clock with sync reset.
*/
`timescale 1ns/100ps
`default_nettype none

module i2c_cond_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus
  i2c_link_if.host lnk,
  // Command port
  input wire logic cmd_valid_i,
  input wire i2c_cond_pkg::host_cmd_t cmd_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_ack_i,
  // Status
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic acked_o,
  output logic owned_o
);

  typedef enum logic [3:0] {
    H_IDLE = 4'h0,
    H_RS0 = 4'h1,
    H_ST1 = 4'h2,
    H_ST2 = 4'h3,
    H_BITL = 4'h4,
    H_BITH = 4'h5,
    H_P0 = 4'h6,
    H_P1 = 4'h7,
    H_P2 = 4'h8
  } host_state_t;

  localparam logic [i2c_cond_pkg::TMR_W-1:0] HALF =
    i2c_cond_pkg::TMR_W'(i2c_cond_pkg::SCL_HALF_CYC);

  logic sda_m, sda_s, scl_m, scl_s;
  host_state_t st, next_st;
  logic [i2c_cond_pkg::TMR_W-1:0] tmr, next_tmr;
  logic [8:0] sh, next_sh, rx, next_rx;
  logic [3:0] cnt, next_cnt;
  logic owned, next_owned, done, next_done;
  logic sda_drv, next_sda_drv, scl_drv, next_scl_drv;
  logic [7:0] rdata, next_rdata;
  logic acked, next_acked;
  logic expire, scl_wait;
  logic ready;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_sh = sh;
    next_rx = rx;
    next_cnt = cnt;
    next_owned = owned;
    next_done = 1'b0;
    next_rdata = rdata;
    next_acked = acked;
    expire = (tmr == i2c_cond_pkg::TMR_ZERO);
    // Released SCL may be stretched by the slave: time only its high part
    scl_wait = (st == H_ST1) | (st == H_BITH) | (st == H_P1);
    case (st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          if (cmd_i == i2c_cond_pkg::CMD_START) begin
            next_st = owned ? H_RS0 : H_ST1;
          end else if (!owned) begin
            next_done = 1'b1;
          end else if (cmd_i == i2c_cond_pkg::CMD_STOP) begin
            next_st = H_P0;
          end else begin
            next_cnt = i2c_cond_pkg::CNT_ZERO;
            next_st = H_BITL;
            // Ninth bit released on write, our acknowledge on read
            next_sh = (cmd_i == i2c_cond_pkg::CMD_WRITE) ? {wdata_i, 1'b1} :
                      {8'hff, ~rd_ack_i};
          end
        end
      end
      H_RS0: if (expire) next_st = H_ST1;
      H_ST1: if (expire) next_st = H_ST2;
      H_ST2: begin
        if (expire) begin
          next_st = H_IDLE;
          next_owned = 1'b1;
          next_done = 1'b1;
        end
      end
      H_BITL: if (expire) next_st = H_BITH;
      H_BITH: begin
        if (expire) begin
          next_rx = {rx[7:0], sda_s};
          next_sh = {sh[7:0], 1'b1};
          next_cnt = cnt + i2c_cond_pkg::CNT_ONE;
          if (cnt == i2c_cond_pkg::BYTE_BITS) begin
            next_st = H_IDLE;
            next_done = 1'b1;
            next_rdata = rx[7:0];
            next_acked = ~sda_s;
          end else begin
            next_st = H_BITL;
          end
        end
      end
      H_P0: if (expire) next_st = H_P1;
      H_P1: if (expire) next_st = H_P2;
      H_P2: begin
        if (expire) begin
          next_st = H_IDLE;
          next_owned = 1'b0;
          next_done = 1'b1;
        end
      end
      default: next_st = H_IDLE;
    endcase
    if (next_st != st) begin
      next_tmr = HALF;
    end else if (scl_wait && !scl_s) begin
      next_tmr = HALF;
    end else if (expire) begin
      next_tmr = tmr;
    end else begin
      next_tmr = tmr - 9'h001;
    end
    next_scl_drv = (next_st == H_RS0) | (next_st == H_BITL) | (next_st == H_P0) |
                   ((next_st == H_IDLE) & next_owned);
    next_sda_drv = (next_st == H_ST2) | (next_st == H_P0) | (next_st == H_P1) |
                   (((next_st == H_BITL) | (next_st == H_BITH)) & ~next_sh[8]);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      st <= H_IDLE;
      tmr <= HALF;
      sh <= 9'h1ff;
      rx <= 9'h000;
      cnt <= i2c_cond_pkg::CNT_ZERO;
      owned <= 1'b0;
      done <= 1'b0;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
      rdata <= 8'h00;
      acked <= 1'b0;
      ready <= 1'b1;
    end else begin
      sda_m <= lnk.sda;
      sda_s <= sda_m;
      scl_m <= lnk.scl;
      scl_s <= scl_m;
      st <= next_st;
      tmr <= next_tmr;
      sh <= next_sh;
      rx <= next_rx;
      cnt <= next_cnt;
      owned <= next_owned;
      done <= next_done;
      sda_drv <= next_sda_drv;
      scl_drv <= next_scl_drv;
      rdata <= next_rdata;
      acked <= next_acked;
      ready <= (next_st == H_IDLE);
    end
  end

  assign lnk.host_sda_o = 1'b0;
  assign lnk.host_scl_o = 1'b0;
  assign lnk.host_sda_oe_n = ~sda_drv;
  assign lnk.host_scl_oe_n = ~scl_drv;
  assign cmd_ready_o = ready;
  assign done_o = done;
  assign rdata_o = rdata;
  assign acked_o = acked;
  assign owned_o = owned;

endmodule

`default_nettype wire

// >>> i2c_cond_pkg.sv
/*
  Shared constants and types for the two-wire bus-condition logic:
  bus timing, address prefix, bit counts and the host command set.
  Assumes a 40 MHz system clock on both ends.
*/
`default_nettype none

package i2c_cond_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SCL_HALF_NS = 5000;
  localparam int T_START_HOLD_NS = 4000;
  // Least times, so round up to whole cycles
  localparam int SCL_HALF_CYC = (T_SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HOLD_CYC = (T_START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 9;
  localparam logic [TMR_W-1:0] TMR_ZERO = 9'h000;

  // ****************************************************************
  // Framing
  // ****************************************************************
  localparam logic [4:0] ADDR10_PREFIX = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ****************************************************************
  // Host commands
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } host_cmd_t;

endpackage

`default_nettype wire

// >>> i2c_link_if.sv
/*
  Shared two-wire bus between the device end and the far-end master.
  Each party offers an open-drain pin as value plus active-low enable;
  the wire level is resolved here with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none

interface i2c_link_if;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic sda;
  logic scl;

  // Wired-AND with pull-up: a line is low only if someone drives it low
  assign sda = ~((~dev_sda_oe_n & ~dev_sda_o) | (~host_sda_oe_n & ~host_sda_o));
  assign scl = ~((~dev_scl_oe_n & ~dev_scl_o) | (~host_scl_oe_n & ~host_scl_o));

  modport dev (
    input sda,
    input scl,
    output dev_sda_o,
    output dev_sda_oe_n,
    output dev_scl_o,
    output dev_scl_oe_n
  );

  modport host (
    input sda,
    input scl,
    output host_sda_o,
    output host_sda_oe_n,
    output host_scl_o,
    output host_scl_oe_n
  );
endinterface

`default_nettype wire

// >>> i2c_start_stop_restart_detect_asserts.sv
/*
  Checker for the bus conditions seen between the two ends.
  Assumes it is placed beside the shared bus and fed its resolved lines.
*/
`timescale 1ns/100ps
`default_nettype none

module i2c_start_stop_restart_detect_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus
  input wire logic sda,
  input wire logic scl,
  input wire logic dev_sda_oe_n,
  input wire logic dev_scl_oe_n,
  // Device side
  input wire logic native_cond_irq_i,
  input wire logic start_detect_irq_enable_i,
  input wire logic stop_detect_irq_enable_i,
  input wire logic start_det_o,
  input wire logic stop_det_o,
  input wire logic restart_det_o,
  input wire logic bus_active_o,
  input wire logic bus_collision_o,
  input wire logic tx_req_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ************************************************************
  // Conditions
  // ************************************************************
  a_start_seen: assert property (scl && $fell(sda) |-> ##[3:5] start_det_o)
    else $error("start not reported");
  // Two sync stages leave no room for an earlier pulse
  a_sync_delay: assert property (scl && $fell(sda) |-> !start_det_o ##1 !start_det_o)
    else $error("start reported too early");
  a_stop_seen: assert property (scl && $rose(sda) && bus_active_o |-> ##[3:5] stop_det_o)
    else $error("stop not reported");
  a_stop_valid: assert property (stop_det_o |-> $past(bus_active_o))
    else $error("stop on idle bus");
  a_restart_only: assert property (restart_det_o |-> start_det_o && bus_active_o)
    else $error("restart outside a transfer");
  a_bus_active: assert property (start_det_o |=> bus_active_o)
    else $error("bus not active after start");
  a_bus_idle: assert property (stop_det_o |-> ##[1:2] !bus_active_o)
    else $error("bus still active after stop");
  a_collision_cause: assert property (bus_collision_o |-> $past(dev_sda_oe_n, 2))
    else $error("collision while driving data");
  a_clock_held: assert property (tx_req_o |-> !dev_scl_oe_n && !scl)
    else $error("clock not held");
  a_start_irq: assert property (start_det_o |->
    irq_o == (native_cond_irq_i || start_detect_irq_enable_i))
    else $error("start interrupt wrong");
  a_stop_irq: assert property (stop_det_o |->
    irq_o == (native_cond_irq_i || stop_detect_irq_enable_i))
    else $error("stop interrupt wrong");

  c_start: cover property (start_det_o);
  c_restart: cover property (restart_det_o);
  c_hold: cover property (tx_req_o);
  c_collision: cover property (bus_collision_o);
endmodule

`default_nettype wire

// >>> test_i2c_start_stop_restart_detect.sv
/*
  Self-checking bench: host end and device end joined on one bus.
  Assumes the shared package, bus interface and both end modules.
*/
`timescale 1ns/100ps
`default_nettype none

module test_i2c_start_stop_restart_detect;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [9:0] own_addr_i = 10'h000;
  logic start_detect_irq_enable_i = 1'b0;
  logic stop_detect_irq_enable_i = 1'b0;
  logic native_cond_irq_i = 1'b0;
  logic gen_start_i = 1'b0;
  logic gen_stop_i = 1'b0;
  logic tx_load_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic cmd_valid_i = 1'b0;
  i2c_cond_pkg::host_cmd_t cmd_i = i2c_cond_pkg::CMD_START;
  logic [7:0] wdata_i = 8'h00;
  logic rd_ack_i = 1'b0;
  logic start_det_o, stop_det_o, restart_det_o, bus_active_o, bus_collision_o;
  logic master_own_o, prior_match_o, addr_match_o, rx_valid_o, tx_req_o, irq_o;
  logic cmd_ready_o, done_o, acked_o, owned_o, own_m;
  logic [7:0] rx_data_o, rdata_o, d;
  logic [9:0] a;
  int error_cnt = 0;
  int checks = 0;
  int seed = 27;
  int n_st = 0, n_sp = 0, n_rs = 0, e_st = 0, e_sp = 0, e_rs = 0;
  int n_co = 0, n_am = 0, n_rv = 0;

  i2c_link_if lnk();
  i2c_cond_device u_i2c_cond_device (.clk_i, .sys_rst_i, .lnk, .own_addr_i,
    .start_detect_irq_enable_i, .stop_detect_irq_enable_i, .native_cond_irq_i,
    .gen_start_i, .gen_stop_i, .tx_load_i, .tx_data_i, .start_det_o, .stop_det_o,
    .restart_det_o, .bus_active_o, .bus_collision_o, .master_own_o, .prior_match_o,
    .addr_match_o, .rx_valid_o, .rx_data_o, .tx_req_o, .irq_o);
  i2c_cond_host u_i2c_cond_host (.clk_i, .sys_rst_i, .lnk, .cmd_valid_i, .cmd_i,
    .wdata_i, .rd_ack_i, .cmd_ready_o, .done_o, .rdata_o, .acked_o, .owned_o);
  i2c_start_stop_restart_detect_asserts u_chk (.clk_i, .sys_rst_i, .sda(lnk.sda),
    .scl(lnk.scl), .dev_sda_oe_n(lnk.dev_sda_oe_n), .dev_scl_oe_n(lnk.dev_scl_oe_n),
    .native_cond_irq_i, .start_detect_irq_enable_i, .stop_detect_irq_enable_i,
    .start_det_o, .stop_det_o, .restart_det_o, .bus_active_o, .bus_collision_o,
    .tx_req_o, .irq_o);

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (start_det_o === 1'b1) n_st++;
    if (stop_det_o === 1'b1) n_sp++;
    if (restart_det_o === 1'b1) n_rs++;
    if (bus_collision_o === 1'b1) n_co++;
    if (addr_match_o === 1'b1) n_am++;
    if (rx_valid_o === 1'b1) n_rv++;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Model: condition counts and ownership follow the commands issued
  task automatic cnt_chk();
    repeat (8) @(negedge clk_i);
    chk(n_st == e_st && n_sp == e_sp && n_rs == e_rs, "condition count");
    chk(bus_active_o === own_m, "bus activity");
  endtask

  task automatic host(input i2c_cond_pkg::host_cmd_t c, input logic [7:0] wd);
    do @(negedge clk_i); while (cmd_ready_o !== 1'b1);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    wdata_i <= wd;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    do @(negedge clk_i); while (done_o !== 1'b1);
    if (c == i2c_cond_pkg::CMD_START) begin
      e_st++;
      e_rs += own_m;
      own_m = 1'b1;
    end
    if (c == i2c_cond_pkg::CMD_STOP) begin
      e_sp += own_m;
      own_m = 1'b0;
    end
    if (c != i2c_cond_pkg::CMD_WRITE) cnt_chk();
  endtask

  task automatic wr(input logic [7:0] wd, input logic ak);
    host(i2c_cond_pkg::CMD_WRITE, wd);
    chk(acked_o === ak, "address acknowledge");
  endtask

  // One-cycle strobe: 0 load, 1 open, 2 close
  task automatic pulse(input int w);
    @(posedge clk_i);
    if (w == 0) begin
      tx_load_i <= 1'b1;
    end else if (w == 1) begin
      gen_start_i <= 1'b1;
    end else begin
      gen_stop_i <= 1'b1;
    end
    @(posedge clk_i);
    tx_load_i <= 1'b0;
    gen_start_i <= 1'b0;
    gen_stop_i <= 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    own_m = 1'b0;
    a = 10'($random(seed));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    own_addr_i <= a;
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      @(posedge clk_i);
      native_cond_irq_i <= i[0];
      start_detect_irq_enable_i <= 1'($random(seed));
      stop_detect_irq_enable_i <= 1'($random(seed));
      host(i2c_cond_pkg::CMD_START, 8'h00);
      wr({5'h1e, a[9:8], 1'b0}, 1'b1);
      wr(a[7:0], 1'b1);
      chk(prior_match_o === 1'b1, "match flag not set");
      wr(d, 1'b1);
      chk(rx_data_o === d, "received byte");
      host(i2c_cond_pkg::CMD_START, 8'h00);
      wr({5'h1e, a[9:8], 1'b1}, 1'b1);
      for (int n = 0; n < 2000 && tx_req_o !== 1'b1; n++) @(negedge clk_i);
      chk(tx_req_o === 1'b1, "clock not held for read");
      @(posedge clk_i);
      tx_data_i <= ~d;
      pulse(0);
      host(i2c_cond_pkg::CMD_READ, 8'h00);
      chk(rdata_o === ~d, "read byte");
      host(i2c_cond_pkg::CMD_STOP, 8'h00);
      chk(prior_match_o === 1'b0, "match flag kept after stop");
    end
    // Refusals: wrong high byte, wrong low byte, read without match, restart then write
    for (int k = 0; k < 4; k++) begin
      host(i2c_cond_pkg::CMD_START, 8'h00);
      if (k == 0) wr({5'h1e, a[9], ~a[8], 1'b0}, 1'b0);
      if (k == 1 || k == 3) wr({5'h1e, a[9:8], 1'b0}, 1'b1);
      if (k == 1) wr(a[7:0] ^ 8'h01, 1'b0);
      if (k == 2) wr({5'h1e, a[9:8], 1'b1}, 1'b0);
      if (k == 3) begin
        wr(a[7:0], 1'b1);
        host(i2c_cond_pkg::CMD_START, 8'h00);
        wr({5'h1e, a[9:8], 1'b0}, 1'b1);
      end
      chk(prior_match_o === 1'b0, "match flag after refusal");
      host(i2c_cond_pkg::CMD_STOP, 8'h00);
    end
    // Device end asks for the bus just as the host pulls SDA low
    fork
      host(i2c_cond_pkg::CMD_START, 8'h00);
      begin
        do @(negedge clk_i); while (lnk.sda !== 1'b0);
        pulse(1);
      end
    join
    chk(n_co == 1 && master_own_o === 1'b0, "start collision");
    host(i2c_cond_pkg::CMD_STOP, 8'h00);
    // Device end opens and closes the bus itself
    pulse(1);
    for (int n = 0; n < 400 && master_own_o !== 1'b1; n++) @(negedge clk_i);
    chk(master_own_o === 1'b1 && bus_collision_o === 1'b0, "own start");
    e_st++;
    own_m = 1'b1;
    cnt_chk();
    pulse(2);
    for (int n = 0; n < 1000 && bus_active_o !== 1'b0; n++) @(negedge clk_i);
    e_sp++;
    own_m = 1'b0;
    cnt_chk();
    chk(n_co == 1 && n_am == 3 && n_rv == 2, "event counts");
    complete_run();
  end

  initial begin
    #(25 * 90000);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    complete_run();
  end
endmodule

`default_nettype wire
